// ==== dctc_pkg.sv ====
// dctc_pkg: constants, codes and carriers shared by the command-timing block
// assumes: a single package compiled ahead of every dctc design file
`default_nettype none
package dctc_pkg;
   localparam int WL_W   = 5;
   localparam int PEND_W = 40;
   localparam int PS_W   = 20;
   localparam int TCK_W  = 12;
   localparam int NCK_W  = 16;
   localparam int DIV_W  = 32;

   // burst field of mode register zero
   localparam logic [1:0] BURST_FIXED_BL8 = 2'h0;
   localparam logic [1:0] BURST_OTF       = 2'h1;
   localparam logic [1:0] BURST_FIXED_BC4 = 2'h2;

   // clocks between write latency expiry and internal write start
   localparam logic [5:0] WR_START_FULL = 6'h04;
   localparam logic [5:0] WR_START_CHOP = 6'h02;
   localparam logic [5:0] ONE_CYCLE     = 6'h01;

   localparam logic [WL_W-1:0] WL_RESET = 5'h09;

   // integer form of the ns to clock rounding
   localparam logic [DIV_W-1:0] ROUND_SCALE = 32'h0000_03E8;
   localparam logic [DIV_W-1:0] ROUND_CORR  = 32'h0000_03CE;
   localparam logic [NCK_W-1:0] NCK_SAT     = 16'hFFFF;
   localparam logic [TCK_W-1:0] TCK_ZERO    = 12'h000;

   typedef struct packed {
      logic [WL_W-1:0] wl;
      logic [1:0]      burst_mode;
   } dctc_cfg_t;

   typedef struct packed {
      logic [PS_W-1:0]  param_ps;
      logic [TCK_W-1:0] tck_ps;
   } dctc_conv_req_t;
endpackage
`default_nettype wire

// ==== dctc_div.sv ====
// dctc_div: serial restoring divider, one quotient bit per clock
// assumes: start is honoured only while idle; divide by zero gives all ones
`default_nettype none
module dctc_div
   import dctc_pkg::*;
#(
   parameter int W = DIV_W
) (
   input  wire logic         clk,      // clock
   input  wire logic         reset,    // synchronous reset, high
   input  wire logic         start,    // begin a division
   input  wire logic [W-1:0] dividend, // numerator, taken on start
   input  wire logic [W-1:0] divisor,  // denominator, taken on start
   output var  logic         busy,     // division in progress
   output var  logic         done,     // one-cycle pulse, quotient valid
   output var  logic [W-1:0] quotient  // result, held until next start
);
   localparam int CW = $clog2(W + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(1);
   localparam logic [CW-1:0] CNT_FULL = CW'(W);

   logic [W-1:0]  rem_r, rem_nxt, quo_r, quo_nxt, dvs_r, dvs_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          busy_r, busy_nxt, done_r, done_nxt;
   logic [W:0]    shifted, diff;

   always_comb begin
      rem_nxt  = rem_r;
      quo_nxt  = quo_r;
      dvs_nxt  = dvs_r;
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      shifted  = {rem_r, quo_r[W-1]};
      diff     = shifted - {1'b0, dvs_r};
      if (start && !busy_r) begin
         quo_nxt  = dividend;
         dvs_nxt  = divisor;
         rem_nxt  = '0;
         cnt_nxt  = CNT_FULL;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (!diff[W]) begin
            rem_nxt = diff[W-1:0];
            quo_nxt = {quo_r[W-2:0], 1'b1};
         end else begin
            rem_nxt = shifted[W-1:0];
            quo_nxt = {quo_r[W-2:0], 1'b0};
         end
         cnt_nxt = cnt_r - CNT_LAST;
         if (cnt_r == CNT_LAST) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rem_r  <= '0;
         quo_r  <= '0;
         dvs_r  <= '0;
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         rem_r  <= rem_nxt;
         quo_r  <= quo_nxt;
         dvs_r  <= dvs_nxt;
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy     = busy_r;
   assign done     = done_r;
   assign quotient = quo_r;
endmodule
`default_nettype wire

// ==== dctc_timing_calc.sv ====
// dctc_timing_calc: device-side write start timing, power-down gating,
// preamble mode decode and ns to clock-count conversion
// assumes: link_clk is the controller-driven memory clock; config from sys_clk logic
`default_nettype none
// Functional notes
// - eight-beat or on-the-fly chop: internal write starts 4 clocks after write latency.
// - chop fixed by mode register: internal write starts 2 clocks after latency.
// - clock-enable low may land mid-operation; power-down current waits for completion.
// - device accepts counts of parameter over average period, rounded up; the code takes 0.025 off the ratio before rounding up.
// - mode register four A11: 0 one-clock, 1 two-clock toggle read preamble.
// - mode register four A12: 0 one-clock, 1 two-clock preamble mode.
module dctc_timing_calc
   import dctc_pkg::*;
(
   input  wire logic             sys_clk,        // system clock, 25 MHz
   input  wire logic             reset,          // synchronous reset, high
   input  wire logic             link_clk,       // memory clock from controller
   input  wire dctc_cfg_t        cfg_in,         // write latency and burst mode
   output var  logic             cfg_sync_busy,  // config transfer to link open
   input  wire logic             mr4_a11,        // read preamble select bit
   input  wire logic             mr4_a12,        // preamble mode select bit
   input  wire logic             speed_hi,       // grade allows two-clock preamble
   output var  logic             rd_pre_2ck,     // two-clock toggle read preamble
   output var  logic             wr_pre_2ck,     // two-clock preamble mode
   output var  logic             pre_illegal,    // two-clock asked on a low grade
   input  wire logic             conv_start,     // start a conversion
   input  wire dctc_conv_req_t   conv_req,       // parameter and period in ps
   output var  logic             conv_busy,      // conversion running
   output var  logic             conv_done,      // one-cycle pulse, result valid
   output var  logic [NCK_W-1:0] conv_nck,       // clock count, saturated
   output var  logic             conv_err,       // zero clock period given
   input  wire logic             write_cmd,      // write command, link domain
   input  wire logic             cke,            // registered clock enable
   input  wire logic             op_busy,        // row, precharge or refresh running
   output var  logic             int_write_start,// internal write start pulse
   output var  logic             pd_current_ok,  // power-down current applies, link
   output var  logic             pd_current_sys  // same, synchronised to sys_clk
);
   // ---------------- preamble decode, sys_clk ----------------
   logic rd_pre_r, rd_pre_nxt, wr_pre_r, wr_pre_nxt, pre_ill_r, pre_ill_nxt;

   always_comb begin
      rd_pre_nxt  = mr4_a11 && speed_hi;
      wr_pre_nxt  = mr4_a12 && speed_hi;
      pre_ill_nxt = (mr4_a11 || mr4_a12) && !speed_hi;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rd_pre_r  <= 1'b0;
         wr_pre_r  <= 1'b0;
         pre_ill_r <= 1'b0;
      end else begin
         rd_pre_r  <= rd_pre_nxt;
         wr_pre_r  <= wr_pre_nxt;
         pre_ill_r <= pre_ill_nxt;
      end
   end

   assign rd_pre_2ck  = rd_pre_r;
   assign wr_pre_2ck  = wr_pre_r;
   assign pre_illegal = pre_ill_r;

   // ---------------- rounding conversion, sys_clk ----------------
   typedef enum logic [2:0] {
      CV_IDLE  = 3'b001,
      CV_SCALE = 3'b010,
      CV_ROUND = 3'b100
   } dctc_cv_st_t;

   dctc_cv_st_t      cv_r, cv_nxt;
   dctc_conv_req_t   req_r, req_nxt;
   logic [NCK_W-1:0] nck_r, nck_nxt;
   logic             done_r, done_nxt, err_r, err_nxt;
   logic             div_start, div_busy, div_done;
   logic [DIV_W-1:0] div_num, div_den, div_q;

   // two passes through one divider: area traded for about 66 cycles latency
   always_comb begin
      cv_nxt    = cv_r;
      req_nxt   = req_r;
      nck_nxt   = nck_r;
      err_nxt   = err_r;
      done_nxt  = 1'b0;
      div_start = 1'b0;
      div_num   = DIV_W'(req_r.param_ps) * ROUND_SCALE;
      div_den   = DIV_W'(req_r.tck_ps);
      case (cv_r)
         CV_IDLE: begin
            if (conv_start) begin
               req_nxt = conv_req;
               if (conv_req.tck_ps == TCK_ZERO) begin
                  err_nxt  = 1'b1;
                  done_nxt = 1'b1;
               end else begin
                  err_nxt = 1'b0;
                  cv_nxt  = CV_SCALE;
               end
            end
         end
         CV_SCALE: begin
            div_start = 1'b1;
            if (div_done) begin
               div_num = div_q + ROUND_CORR;
               div_den = ROUND_SCALE;
               cv_nxt  = CV_ROUND;
            end
         end
         CV_ROUND: begin
            if (div_done) begin
               nck_nxt  = (div_q[DIV_W-1:NCK_W] != '0) ? NCK_SAT : div_q[NCK_W-1:0];
               done_nxt = 1'b1;
               cv_nxt   = CV_IDLE;
            end
         end
         default: cv_nxt = CV_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cv_r   <= CV_IDLE;
         req_r  <= '0;
         nck_r  <= '0;
         done_r <= 1'b0;
         err_r  <= 1'b0;
      end else begin
         cv_r   <= cv_nxt;
         req_r  <= req_nxt;
         nck_r  <= nck_nxt;
         done_r <= done_nxt;
         err_r  <= err_nxt;
      end
   end

   // only start while in SCALE or on the SCALE done edge; divider ignores busy starts
   dctc_div #(.W(DIV_W)) u_div (
      .clk      (sys_clk),
      .reset    (reset),
      .start    (div_start && (!div_busy || div_done)),
      .dividend (div_num),
      .divisor  (div_den),
      .busy     (div_busy),
      .done     (div_done),
      .quotient (div_q)
   );

   assign conv_busy = (cv_r != CV_IDLE);
   assign conv_done = done_r;
   assign conv_nck  = nck_r;
   assign conv_err  = err_r;

   // ---------------- config handshake sys -> link ----------------
   dctc_cfg_t cfg_hold_r, cfg_hold_nxt;
   logic      req_tgl_r, req_tgl_nxt;
   logic      ack_s1_r, ack_s2_r, ack_s3_r;
   logic      lrst_meta_r, lrst_r;
   logic      req_s1_r, req_s2_r, req_s3_r, ack_tgl_r;
   dctc_cfg_t cfg_l_r, cfg_l_nxt;

   always_comb begin
      cfg_hold_nxt = cfg_hold_r;
      req_tgl_nxt  = req_tgl_r;
      // held word stays stable until the link acknowledges it
      if ((req_tgl_r == ack_s3_r) && (cfg_in != cfg_hold_r)) begin
         cfg_hold_nxt = cfg_in;
         req_tgl_nxt  = !req_tgl_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_hold_r <= '{wl: WL_RESET, burst_mode: BURST_FIXED_BL8};
         req_tgl_r  <= 1'b0;
         ack_s1_r   <= 1'b0;
         ack_s2_r   <= 1'b0;
         ack_s3_r   <= 1'b0;
      end else begin
         cfg_hold_r <= cfg_hold_nxt;
         req_tgl_r  <= req_tgl_nxt;
         ack_s1_r   <= ack_tgl_r;
         ack_s2_r   <= ack_s1_r;
         ack_s3_r   <= ack_s2_r;
      end
   end

   assign cfg_sync_busy = (req_tgl_r != ack_s3_r);

   // reset reaches the link domain through two flops
   always_ff @(posedge link_clk) begin
      lrst_meta_r <= reset;
      lrst_r      <= lrst_meta_r;
   end

   always_comb begin
      cfg_l_nxt = cfg_l_r;
      if (req_s2_r != req_s3_r) begin
         cfg_l_nxt = cfg_hold_r;
      end
   end

   // ---------------- write start and power-down, link_clk ----------------
   logic [PEND_W-1:0] pend_r, pend_nxt;
   logic [5:0]        wr_dly;
   logic              pd_r, pd_nxt;

   always_comb begin
      wr_dly   = {1'b0, cfg_l_r.wl}
               + ((cfg_l_r.burst_mode == BURST_FIXED_BC4) ? WR_START_CHOP
                                                         : WR_START_FULL);
      pend_nxt = {1'b0, pend_r[PEND_W-1:1]};
      if (write_cmd) begin
         pend_nxt[wr_dly - ONE_CYCLE] = 1'b1;
      end
      pd_nxt = !cke && !op_busy;
   end

   always_ff @(posedge link_clk) begin
      if (lrst_r) begin
         req_s1_r  <= 1'b0;
         req_s2_r  <= 1'b0;
         req_s3_r  <= 1'b0;
         ack_tgl_r <= 1'b0;
         cfg_l_r   <= '{wl: WL_RESET, burst_mode: BURST_FIXED_BL8};
         pend_r    <= '0;
         pd_r      <= 1'b0;
      end else begin
         req_s1_r  <= req_tgl_r;
         req_s2_r  <= req_s1_r;
         req_s3_r  <= req_s2_r;
         ack_tgl_r <= req_s3_r;
         cfg_l_r   <= cfg_l_nxt;
         pend_r    <= pend_nxt;
         pd_r      <= pd_nxt;
      end
   end

   assign int_write_start = pend_r[0];
   assign pd_current_ok   = pd_r;

   // power-down status back to sys_clk, taken when stages two and three agree
   logic pd_s1_r, pd_s2_r, pd_s3_r, pd_sys_r, pd_sys_nxt;

   always_comb begin
      pd_sys_nxt = (pd_s2_r == pd_s3_r) ? pd_s3_r : pd_sys_r;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pd_s1_r  <= 1'b0;
         pd_s2_r  <= 1'b0;
         pd_s3_r  <= 1'b0;
         pd_sys_r <= 1'b0;
      end else begin
         pd_s1_r  <= pd_r;
         pd_s2_r  <= pd_s1_r;
         pd_s3_r  <= pd_s2_r;
         pd_sys_r <= pd_sys_nxt;
      end
   end

   assign pd_current_sys = pd_sys_r;

   // ---------------- checks ----------------
   logic [5:0]       hlp_cnt_r;
   logic             hlp_chop_r;
   logic [DIV_W-1:0] hlp_ref;

   // follows one write at a time to time its start
   always_ff @(posedge link_clk) begin
      if (lrst_r) begin
         hlp_cnt_r  <= '0;
         hlp_chop_r <= 1'b0;
      end else if (hlp_cnt_r != '0) begin
         hlp_cnt_r <= hlp_cnt_r - ONE_CYCLE;
      end else if (write_cmd) begin
         hlp_chop_r <= (cfg_l_r.burst_mode == BURST_FIXED_BC4);
         hlp_cnt_r  <= {1'b0, cfg_l_r.wl} + ((cfg_l_r.burst_mode == BURST_FIXED_BC4)
                     ? WR_START_CHOP : WR_START_FULL);
      end
   end

   always_comb begin
      hlp_ref = '0;
      if (req_r.tck_ps != TCK_ZERO) begin
         hlp_ref = ((DIV_W'(req_r.param_ps) * ROUND_SCALE) / DIV_W'(req_r.tck_ps) + ROUND_CORR)
                 / ROUND_SCALE;
      end
   end

   a_wr_start_full: assert property (@(posedge link_clk) disable iff (lrst_r)
      (hlp_cnt_r == ONE_CYCLE) && !hlp_chop_r |-> int_write_start)
      else $error("internal write start missed after latency plus four");
   a_wr_start_chop: assert property (@(posedge link_clk) disable iff (lrst_r)
      (hlp_cnt_r == ONE_CYCLE) && hlp_chop_r |-> int_write_start)
      else $error("internal write start missed after latency plus two");
   a_pd_busy_block: assert property (@(posedge link_clk) disable iff (lrst_r)
      op_busy |=> !pd_current_ok)
      else $error("power-down current flagged while an operation runs");
   a_pd_enter_idle: assert property (@(posedge link_clk) disable iff (lrst_r)
      !cke && !op_busy |=> pd_current_ok)
      else $error("power-down current not flagged when idle with clock enable low");
   a_rd_pre_two: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(mr4_a11) && speed_hi |=> rd_pre_2ck && !pre_illegal)
      else $error("two-clock read preamble not selected");
   a_rd_pre_low: assert property (@(posedge sys_clk) disable iff (reset)
      mr4_a11 && !speed_hi |=> !rd_pre_2ck && pre_illegal)
      else $error("two-clock read preamble allowed on a low grade");
   a_wr_pre_two: assert property (@(posedge sys_clk) disable iff (reset)
      !mr4_a12 ##1 mr4_a12 && speed_hi |=> wr_pre_2ck)
      else $error("two-clock preamble mode not selected");
   a_wr_pre_low: assert property (@(posedge sys_clk) disable iff (reset)
      mr4_a12 && !speed_hi |=> !wr_pre_2ck && pre_illegal)
      else $error("two-clock preamble mode allowed on a low grade");
   a_conv_exact: assert property (@(posedge sys_clk) disable iff (reset)
      conv_done && !conv_err && (hlp_ref[DIV_W-1:NCK_W] == '0)
      |-> conv_nck == hlp_ref[NCK_W-1:0])
      else $error("clock count differs from rounded ratio");
   a_conv_bound: assert property (@(posedge sys_clk) disable iff (reset)
      conv_start && !conv_busy |-> ##[1:80] conv_done)
      else $error("conversion did not finish in time");

   c_full_start: cover property (@(posedge link_clk) disable iff (lrst_r)
      (hlp_cnt_r == ONE_CYCLE) && !hlp_chop_r && int_write_start);
   c_chop_start: cover property (@(posedge link_clk) disable iff (lrst_r)
      (hlp_cnt_r == ONE_CYCLE) && hlp_chop_r && int_write_start);
   c_pd_sys: cover property (@(posedge sys_clk) disable iff (reset) $rose(pd_current_sys));
   c_conv_ok: cover property (@(posedge sys_clk) disable iff (reset) conv_done && !conv_err);
endmodule
`default_nettype wire

// ==== dctc_ctrl_model.sv ====
// dctc_ctrl_model: controller-side model, memory clock and link-domain command lines
// assumes: the bench calls its tasks one at a time; only writes are ever issued
`default_nettype none
module dctc_ctrl_model (
   output var  logic link_clk,        // memory clock, 6 ns, free running
   output var  logic write_cmd,       // write command
   output var  logic cke,             // registered clock enable
   output var  logic op_busy,         // row, precharge or refresh in progress
   input  wire logic int_write_start  // internal write start from the device
);
   timeunit 1ns;
   timeprecision 100ps;

   // odd offset keeps the memory clock unrelated in phase to sys_clk
   initial begin
      link_clk = 1'b0;
      #1.7;
      // slow fixed period: only the refresh interval would bound it, lowest-grade timings apply
      forever #3 link_clk = ~link_clk;
   end

   // reads and synchronous termination need a locked loop; this model never sends them
   initial begin
      // only writes go out, so no mode-register-seven spacing,
      // write-recovery or CRC-plus-mask delay choice ever arises here
      write_cmd = 1'b0;
      cke       = 1'b1;
      op_busy   = 1'b0;
   end

   // one write, or two on consecutive edges; returns the edge at which the
   // first start pulse is sampled and how many pulses were seen
   task automatic do_write(input int twice, output int lat, output int pulses);
      int n;
      lat    = -1;
      pulses = 0;
      @(posedge link_clk);
      #1 write_cmd = 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge link_clk);
         #1;
         if (n == twice) write_cmd = 1'b0;
         if (int_write_start === 1'b1) begin
            pulses++;
            if (lat < 0) lat = n + 1;
         end
      end
   endtask

   // clock enable may go low while an operation is still running
   task automatic set_pd(input logic cke_v, input logic busy_v);
      @(posedge link_clk);
      #1 cke = cke_v;
      op_busy = busy_v;
      @(posedge link_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== tb_dctc_timing_calc.sv ====
// tb_dctc_timing_calc: self-checking bench for the command-timing block
// assumes: dctc_pkg compiled first; dctc_ctrl_model stands on the link side
`default_nettype none
module tb_dctc_timing_calc
   import dctc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic             sys_clk, reset, mr4_a11, mr4_a12, speed_hi, conv_start;
   dctc_cfg_t        cfg_in;
   dctc_conv_req_t   conv_req;
   logic             cfg_sync_busy, rd_pre_2ck, wr_pre_2ck, pre_illegal;
   logic             conv_busy, conv_done, conv_err;
   logic [NCK_W-1:0] conv_nck;
   logic             link_clk, write_cmd, cke, op_busy;
   logic             int_write_start, pd_current_ok, pd_current_sys;
   int               errors = 0;
   int               check_count = 0;
   logic [15:0]      rnd = 16'h0027;

   dctc_timing_calc dut (.sys_clk(sys_clk), .reset(reset), .link_clk(link_clk),
      .cfg_in(cfg_in), .cfg_sync_busy(cfg_sync_busy), .mr4_a11(mr4_a11),
      .mr4_a12(mr4_a12), .speed_hi(speed_hi), .rd_pre_2ck(rd_pre_2ck),
      .wr_pre_2ck(wr_pre_2ck), .pre_illegal(pre_illegal), .conv_start(conv_start),
      .conv_req(conv_req), .conv_busy(conv_busy), .conv_done(conv_done),
      .conv_nck(conv_nck), .conv_err(conv_err), .write_cmd(write_cmd), .cke(cke),
      .op_busy(op_busy), .int_write_start(int_write_start),
      .pd_current_ok(pd_current_ok), .pd_current_sys(pd_current_sys));

   dctc_ctrl_model pm (.link_clk(link_clk), .write_cmd(write_cmd), .cke(cke),
      .op_busy(op_busy), .int_write_start(int_write_start));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // integer form of the rounding, saturated to the result width
   function automatic logic [15:0] exp_nck(input logic [19:0] p, input logic [11:0] t);
      longint q;
      q = (longint'(p) * 1000) / longint'(t);
      q = (q + 974) / 1000;
      return (q > 65535) ? 16'hFFFF : q[15:0];
   endfunction

   // real form of the rounding, saturated like the integer form
   function automatic logic [15:0] exp_nck_real(input logic [19:0] p, input logic [11:0] t);
      real r;
      r = $ceil(real'(p) / real'(t) - 0.025);
      return (r > 65535.0) ? 16'hFFFF : 16'(longint'(r));
   endfunction

   function automatic int exp_lat(input logic [4:0] wl, input logic [1:0] bm);
      return (bm == BURST_FIXED_BC4) ? int'(wl) + 2 : int'(wl) + 4;
   endfunction

   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic timed_out(input string what);
      errors++;
      $display("[ERR] %s expected done seen timeout", what);
      give_verdict();
   endtask

   task automatic set_cfg(input logic [4:0] wl, input logic [1:0] bm);
      int n;
      @(posedge sys_clk);
      #2 cfg_in = '{wl: wl, burst_mode: bm};
      repeat (3) @(posedge sys_clk);
      #2;
      for (n = 0; n < 100 && cfg_sync_busy !== 1'b0; n++) begin
         @(posedge sys_clk);
         #2;
      end
      if (n == 100) timed_out("cfg_sync_busy");
      repeat (4) @(posedge sys_clk);
   endtask

   // poke raises start again mid-run with other operands, which must be ignored
   task automatic run_conv(input logic [19:0] p, input logic [11:0] t, input bit poke);
      int n;
      @(posedge sys_clk);
      #2 conv_req = '{param_ps: p, tck_ps: t};
      conv_start = 1'b1;
      @(posedge sys_clk);
      #2 conv_start = 1'b0;
      chk("conv_busy", 32'(t != 12'h000), 32'(conv_busy));
      if (poke) begin
         repeat (5) @(posedge sys_clk);
         #2 conv_req = '{param_ps: ~p, tck_ps: 12'h001};
         conv_start = 1'b1;
         @(posedge sys_clk);
         #2 conv_start = 1'b0;
      end
      for (n = 0; n < 200; n++) begin
         if (conv_done === 1'b1) break;
         @(posedge sys_clk);
         #2;
      end
      if (n == 200) timed_out("conv_done");
      chk("conv_idle", 32'h0, 32'(conv_busy));
      chk("conv_err", 32'(t == 12'h000), 32'(conv_err));
      if (t != 12'h000) chk("conv_nck", 32'(exp_nck(p, t)), 32'(conv_nck));
   endtask

   int          i, lat, pulses;
   logic [4:0]  wl;
   logic [1:0]  bm;
   logic [19:0] cp [5] = '{20'h014EB, 20'hFFFFF, 20'h00000, 20'h035B6, 20'h01000};
   logic [11:0] ct [5] = '{12'h42F, 12'h001, 12'h3A9, 12'h42F, 12'h000};

   initial begin
      reset = 1'b1;
      cfg_in = '{wl: WL_RESET, burst_mode: BURST_FIXED_BL8};
      {mr4_a11, mr4_a12, speed_hi, conv_start} = 4'h0;
      conv_req = '0;
      repeat (8) @(posedge sys_clk);
      #2 reset = 1'b0;
      for (i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         // the second-last step clears both select bits on a high grade, the last raises both
         #2 {mr4_a11, mr4_a12, speed_hi} = (i < 8) ? i[2:0] : (i == 8) ? 3'h1 : 3'h7;
         @(posedge sys_clk);
         #2;
         chk("rd_pre_2ck", 32'(mr4_a11 & speed_hi), 32'(rd_pre_2ck));
         chk("wr_pre_2ck", 32'(mr4_a12 & speed_hi), 32'(wr_pre_2ck));
         chk("pre_illegal", 32'((mr4_a11 | mr4_a12) & !speed_hi), 32'(pre_illegal));
      end
      for (i = 0; i < 5; i++) begin
         run_conv(cp[i], ct[i], 1'b0);
         if (ct[i] != 12'h000)
            chk("real", 32'(exp_nck_real(cp[i], ct[i])), 32'(exp_nck(cp[i], ct[i])));
      end
      run_conv(20'h0ABCD, 12'h271, 1'b1);
      run_conv(20'h03A98, 12'h42F, 1'b0);
      for (i = 0; i < 12; i++) begin
         rnd = lfsr_next(rnd);
         cp[0] = {rnd[3:0], rnd};
         rnd = lfsr_next(rnd);
         run_conv(cp[0], rnd[11:0] | 12'h001, 1'b0);
      end
      for (i = 0; i < 10; i++) begin
         rnd = lfsr_next(rnd);
         wl = (i == 0) ? WL_RESET : (i == 1) ? 5'h1F : (rnd[4:0] | 5'h04);
         bm = i[1:0];
         set_cfg(wl, bm);
         pm.do_write(i % 2, lat, pulses);
         chk("write_start_edge", 32'(exp_lat(wl, bm)), 32'(lat));
         chk("write_pulses", 32'(i % 2 + 1), 32'(pulses));
      end
      pm.set_pd(1'b0, 1'b1);
      chk("pd_ok_busy", 32'h0, 32'(pd_current_ok));
      pm.set_pd(1'b0, 1'b0);
      chk("pd_ok_idle", 32'h1, 32'(pd_current_ok));
      repeat (6) @(posedge sys_clk);
      #2 chk("pd_sys_idle", 32'h1, 32'(pd_current_sys));
      pm.set_pd(1'b1, 1'b0);
      chk("pd_ok_awake", 32'h0, 32'(pd_current_ok));
      repeat (6) @(posedge sys_clk);
      #2 chk("pd_sys_awake", 32'h0, 32'(pd_current_sys));
      give_verdict();
   end
endmodule
`default_nettype wire
